// [hw/an_defs.svh]
// Offsets, field positions, reset values and masks of the
// auto-negotiation ability registers.
// Assumes a 5-bit management register index and 16-bit words.
`ifndef AN_DEFS_SVH
`define AN_DEFS_SVH

`define IDX_ADVERT   5'h04
`define IDX_PARTNER  5'h05
`define IDX_EXPAN    5'h06

`define ADV_RESET    16'h0081
`define ADV_WR_MASK  16'h2dff
`define PART_RESET   16'h0001
`define PART_MASK    16'h27ff

`define B_NEXT_PAGE  15
`define B_ACK        14
`define B_RFAULT     13
`define B_PAUSE_ASYM 11
`define B_PAUSE_SYM  10
`define B_100FD      8
`define B_100HD      7
`define B_10FD       6
`define B_10HD       5

`define E_PD_FAULT   4
`define E_LP_NP      3
`define E_PAGE_RX    1
`define E_LP_AN      0

`define PAUSE_NONE   2'h0
`define PAUSE_SYM    2'h1
`define PAUSE_ASYM   2'h2

`endif

// [hw/an_pkg.sv]
// Types shared by the auto-negotiation ability registers.
// Assumes the management engine presents one request per cycle.
package an_pkg;

    // One management access, decoded from the serial frame
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  index;
        logic [15:0] wdata;
    } mgmt_req_t;

    // Base page word handed over by the arbitration logic
    typedef struct packed {
        logic        valid;
        logic [15:0] word;
    } page_t;

    // Resolved speed and duplex
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } link_mode_t;

    typedef enum logic {ST_SAMPLE, ST_HELD} strap_state_t;

endpackage : an_pkg

// [hw/autoneg_ability_registers.sv]
// Auto-negotiation advertisement, partner ability and expansion
// registers with pause and speed/duplex resolution.
// Assumes the management engine and arbitration logic share CLOCK.
`timescale 1ns/1ps
`include "an_defs.svh"
module autoneg_ability_registers
    import an_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // Mode configuration strap pins
    input  wire logic [2:0]  MODE,
    // Management access
    input  wire mgmt_req_t   MGMT_REQ,
    output logic      [15:0] MGMT_RDATA,
    // Arbitration logic status
    input  wire page_t       PAGE,
    input  wire logic        PD_FAULT,
    input  wire logic        LP_AN_ABLE,
    input  wire logic        AN_COMPLETE,
    // Basic control bits
    input  wire logic        AN_ENABLE,
    input  wire logic        MAN_SPEED_100,
    input  wire logic        MAN_FULL_DUPLEX,
    // Results toward the transceiver
    output logic      [15:0] ADVERT_WORD,
    output logic      [1:0]  PAUSE_CFG,
    output link_mode_t       LINK_MODE
);

    // Register state
    logic [15:0]  partner;
    logic         pd_fault;
    logic         page_rx;
    logic         lp_np;
    logic         lp_an;
    strap_state_t strap_state;

    // Next values
    logic [15:0]  next_advert;
    logic [15:0]  next_partner;
    logic         next_pd_fault;
    logic         next_page_rx;
    logic         next_lp_np;
    logic         next_lp_an;
    strap_state_t next_strap_state;
    logic [15:0]  next_rdata;
    logic [1:0]   next_pause;
    link_mode_t   next_mode;

    // Decoded accesses and derived values
    logic         wr_adv;
    logic         rd_exp;
    logic [2:0]   mode_val;
    logic         mode_agree;
    logic [15:0]  expansion;
    logic [3:0]   common;

    // True for a request at the given index
    function automatic logic hit(input logic req, input logic [4:0] idx);
        hit = req && (MGMT_REQ.index == idx);
    endfunction : hit

    // Strap pins through three stages
    strap_sync #(
        .WIDTH (3)
    ) u_mode_sync (
        .clk   (CLOCK),
        .rstn  (RSTN),
        .pin   (MODE),
        .value (mode_val),
        .agree (mode_agree)
    );

    assign wr_adv = hit(MGMT_REQ.wr, `IDX_ADVERT);
    assign rd_exp = hit(MGMT_REQ.rd, `IDX_EXPAN);

    // local next page bit stays zero
    assign expansion = {11'h000, pd_fault, lp_np, 1'b0, page_rx, lp_an};

    // Abilities both ends advertise
    assign common = ADVERT_WORD[`B_100FD:`B_10HD]
                  & partner[`B_100FD:`B_10HD];

    // Advertisement and strap capture
    always_comb
    begin
        next_advert      = ADVERT_WORD;
        next_strap_state = strap_state;
        unique case (strap_state)
            ST_SAMPLE:
            begin
                // straps fill bits 8, 6, 5
                if (mode_agree)
                begin
                    next_advert[`B_100FD] = mode_val[2];
                    next_advert[`B_10FD]  = mode_val[1];
                    next_advert[`B_10HD]  = mode_val[0];
                    next_strap_state      = ST_HELD;
                end
            end
            ST_HELD:
            begin
                next_strap_state = ST_HELD;
            end
        endcase
        if (wr_adv)
        begin
            next_advert = MGMT_REQ.wdata & `ADV_WR_MASK;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            ADVERT_WORD <= `ADV_RESET;
            strap_state <= ST_SAMPLE;
        end
        else
        begin
            ADVERT_WORD <= next_advert;
            strap_state <= next_strap_state;
        end
    end

    // Partner page and expansion status
    always_comb
    begin
        next_partner = partner;
        next_lp_np   = lp_np;
        if (PAGE.valid)
        begin
            next_partner = PAGE.word & `PART_MASK;
            next_partner[`B_ACK] = 1'b1;
            next_lp_np = PAGE.word[`B_NEXT_PAGE];
        end
        // fault latch, set beats read clear
        next_pd_fault = PD_FAULT | (pd_fault & ~rd_exp);
        // page latch, set beats read clear
        next_page_rx  = PAGE.valid | (page_rx & ~rd_exp);
        next_lp_an    = LP_AN_ABLE;
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            partner  <= `PART_RESET;
            pd_fault <= 1'b0;
            page_rx  <= 1'b0;
            lp_np    <= 1'b0;
            lp_an    <= 1'b0;
        end
        else
        begin
            partner  <= next_partner;
            pd_fault <= next_pd_fault;
            page_rx  <= next_page_rx;
            lp_np    <= next_lp_np;
            lp_an    <= next_lp_an;
        end
    end

    // Read data, captured before any latch clears
    always_comb
    begin
        next_rdata = MGMT_RDATA;
        if (MGMT_REQ.rd)
        begin
            unique case (MGMT_REQ.index)
                `IDX_ADVERT:  next_rdata = ADVERT_WORD;
                `IDX_PARTNER: next_rdata = partner;
                `IDX_EXPAN:   next_rdata = expansion;
                default:      next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            MGMT_RDATA <= 16'h0000;
        end
        else
        begin
            MGMT_RDATA <= next_rdata;
        end
    end

    // Pause and speed/duplex resolution
    always_comb
    begin
        next_pause = `PAUSE_NONE;
        if (AN_COMPLETE && partner[`B_PAUSE_SYM])
        begin
            if (ADVERT_WORD[`B_PAUSE_SYM])
            begin
                next_pause = `PAUSE_SYM;
            end
            else if (ADVERT_WORD[`B_PAUSE_ASYM])
            begin
                next_pause = `PAUSE_ASYM;
            end
        end
        next_mode = LINK_MODE;
        if (!AN_ENABLE)
        begin
            next_mode.speed_100   = MAN_SPEED_100;
            next_mode.full_duplex = MAN_FULL_DUPLEX;
        end
        else if (AN_COMPLETE)
        begin
            next_mode.speed_100   = common[3] | common[2];
            next_mode.full_duplex = common[3]
                                  | (~common[2] & common[1]);
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            PAUSE_CFG <= `PAUSE_NONE;
            LINK_MODE <= '0;
        end
        else
        begin
            PAUSE_CFG <= next_pause;
            LINK_MODE <= next_mode;
        end
    end

    // Checks on the register behaviour
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RSTN);

    a_adv_write_lands: assert property (
        wr_adv |=> ADVERT_WORD == ($past(MGMT_REQ.wdata) & `ADV_WR_MASK))
        else $error("advertisement write not stored");

    a_adv_reserved_zero: assert property (
        (ADVERT_WORD & ~`ADV_WR_MASK) == 16'h0000)
        else $error("advertisement reserved bit set");

    a_strap_loads: assert property (
        (strap_state == ST_SAMPLE && mode_agree && !wr_adv)
        |=> ADVERT_WORD[`B_100FD] == $past(mode_val[2])
            && ADVERT_WORD[`B_10HD] == $past(mode_val[0])
            && strap_state == ST_HELD)
        else $error("strap value not loaded");

    a_pause_single: assert property (
        PAUSE_CFG != 2'h3 && (!$past(AN_COMPLETE) -> PAUSE_CFG == 2'h0))
        else $error("pause resolved to both kinds");

    a_partner_np_zero: assert property (
        hit(MGMT_REQ.rd, `IDX_PARTNER) |=> !MGMT_RDATA[`B_NEXT_PAGE])
        else $error("partner next page bit read one");

    a_ack_on_page: assert property (
        PAGE.valid |=> partner[`B_ACK] && partner[9:5] == $past(PAGE.word[9:5]))
        else $error("partner page not mirrored");

    a_fault_holds: assert property (
        (pd_fault && !rd_exp) |=> pd_fault)
        else $error("fault latch dropped without read");

    a_read_clears: assert property (
        (rd_exp && !PD_FAULT && !PAGE.valid) |=> !pd_fault && !page_rx)
        else $error("latched bits not cleared by read");

    a_read_shows_latch: assert property (
        (rd_exp && page_rx) |=> MGMT_RDATA[`E_PAGE_RX] && !MGMT_RDATA[2])
        else $error("page received not reported on read");

    a_manual_mode: assert property (
        !AN_ENABLE ##1 !AN_ENABLE |-> LINK_MODE.speed_100
            == $past(MAN_SPEED_100) && LINK_MODE.full_duplex
            == $past(MAN_FULL_DUPLEX))
        else $error("manual speed or duplex not applied");

    c_page_then_read: cover property (
        PAGE.valid ##[1:20] rd_exp);
    c_strap_loaded: cover property (
        strap_state == ST_SAMPLE ##1 strap_state == ST_HELD);
    c_pause_sym: cover property (PAUSE_CFG == `PAUSE_SYM);
    c_auto_100fd: cover property (
        AN_ENABLE && LINK_MODE.speed_100 && LINK_MODE.full_duplex);

endmodule : autoneg_ability_registers

// [hw/strap_sync.sv]
// Three-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to CLOCK; stage one feeds stage two only.
`timescale 1ns/1ps
module strap_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // Pin side and synchronised side
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] value,
    output logic                  agree
);

    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [1:0]       fill;
    logic [1:0]       next_fill;

    // Count edges until stage three holds a pin sample, not a reset zero
    always_comb
    begin
        next_fill = fill;
        if (fill != 2'h3)
        begin
            next_fill = fill + 2'h1;
        end
    end

    // Shift chain
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            fill <= 2'h0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            fill <= next_fill;
        end
    end

    // Value counts once stages two and three agree
    assign value = s3;
    // Reset zeros in stages two and three must not count as agreement
    assign agree = (fill == 2'h3) && (s2 == s3);

endmodule : strap_sync

// [tb/autoneg_ability_registers_tb.sv]
// Self-checking bench for the auto-negotiation ability registers.
// Assumes the station model and the block share one 50 MHz clock.
`timescale 1ns/1ps
`include "an_defs.svh"
module autoneg_ability_registers_tb
    import an_pkg::*;
;
    logic       clock, rstn, pd_fault, lp_an_able, an_complete;
    logic       an_enable, man_speed_100, man_full_duplex;
    logic       rd_seen = 1'b0;
    logic [2:0] mode;
    mgmt_req_t  mgmt_req;
    page_t      page;
    link_mode_t link_mode;
    logic [15:0] mgmt_rdata, advert_word, adv, w;
    logic [1:0]  pause_cfg;
    logic [15:0] exp_q[$];
    int          err_total = 0;
    int          checked = 0;
    const logic [1:0] pause_exp [4] = '{2'h0, 2'h1, 2'h2, 2'h1};

    autoneg_ability_registers dut_u (.CLOCK(clock), .RSTN(rstn),
        .MODE(mode), .MGMT_REQ(mgmt_req), .MGMT_RDATA(mgmt_rdata),
        .PAGE(page), .PD_FAULT(pd_fault), .LP_AN_ABLE(lp_an_able),
        .AN_COMPLETE(an_complete), .AN_ENABLE(an_enable),
        .MAN_SPEED_100(man_speed_100), .MAN_FULL_DUPLEX(man_full_duplex),
        .ADVERT_WORD(advert_word), .PAUSE_CFG(pause_cfg),
        .LINK_MODE(link_mode));
    mgmt_station sta_u (.clk(clock), .req(mgmt_req));

    // Clock
    always #10 clock = ~clock;

    task automatic cmp(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    // Read answer compare
    task automatic cmp_rdata(input logic [15:0] e);
        cmp("MGMT_RDATA", e, mgmt_rdata);
    endtask : cmp_rdata

    // Advertisement output compare
    task automatic cmp_advert(input logic [15:0] e);
        cmp("ADVERT_WORD", e, advert_word);
    endtask : cmp_advert

    // Resolved pause compare
    task automatic cmp_pause(input logic [1:0] e);
        cmp("PAUSE_CFG", {14'h0, e}, {14'h0, pause_cfg});
    endtask : cmp_pause

    // Resolved speed and duplex compare
    task automatic cmp_mode(input logic [1:0] e);
        cmp("LINK_MODE", {14'h0, e}, {14'h0, link_mode});
    endtask : cmp_mode

    task automatic rd(input logic [4:0] idx, input logic [15:0] e);
        exp_q.push_back(e);
        sta_u.access(1'b1, 1'b0, idx, 16'h0000);
    endtask : rd

    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        sta_u.access(1'b0, 1'b1, idx, d);
    endtask : wr

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    // One-cycle page and fault events from the arbitration side
    task automatic arb(input logic pv, input logic pf, input logic [15:0] d);
        tick(1);
        page = '{valid: pv, word: d};
        pd_fault = pf;
        tick(1);
        page = '{valid: 1'b0, word: ~d};
        pd_fault = 1'b0;
    endtask : arb

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    // Read answer monitor: one cycle after each taken read
    always @(posedge clock) rd_seen <= rstn & mgmt_req.rd;
    always @(negedge clock)
        if (rd_seen)
            cmp_rdata(exp_q.pop_front());

    // Watchdog
    initial
    begin
        #100000;
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        clock = 0; rstn = 0; pd_fault = 0; an_complete = 0; an_enable = 0;
        man_speed_100 = 0; man_full_duplex = 0;
        page = '0;
        lp_an_able = 1;
        void'($urandom(25));
        mode = 3'($urandom);
        repeat (12) @(posedge clock);
        #1 rstn = 1;
        tick(4);
        adv = {7'h00, mode[2], 1'b1, mode[1], mode[0], 5'h01};
        cmp_advert(adv);
        rd(`IDX_ADVERT, adv);
        rd(`IDX_PARTNER, 16'h0001);
        rd(`IDX_EXPAN, 16'h0001);
        w = 16'($urandom);
        wr(`IDX_ADVERT, w);
        cmp_advert(w & `ADV_WR_MASK);
        rd(`IDX_ADVERT, w & 16'h2dff);
        wr(`IDX_PARTNER, ~w);
        wr(`IDX_EXPAN, ~w);
        rd(`IDX_PARTNER, 16'h0001);
        rd(`IDX_EXPAN, 16'h0001);
        rd(5'h07, 16'h0000);
        w = 16'($urandom);
        arb(1'b1, 1'b0, w);
        rd(`IDX_PARTNER, (w & 16'h27ff) | 16'h4000);
        rd(`IDX_EXPAN, {12'h000, w[15], 3'b011});
        rd(`IDX_EXPAN, {12'h000, w[15], 3'b001});
        arb(1'b0, 1'b1, w);
        rd(`IDX_EXPAN, {11'h000, 1'b1, w[15], 3'b001});
        rd(`IDX_EXPAN, {12'h000, w[15], 3'b001});
        // Partner with pause and all abilities, then each local code
        arb(1'b1, 1'b0, 16'h05e1);
        an_enable = 1;
        an_complete = 1;
        for (int c = 0; c < 4; c++)
        begin
            wr(`IDX_ADVERT, {4'h0, 2'(c), 10'h1e1});
            tick(2);
            cmp_pause(pause_exp[c]);
        end
        cmp_mode(2'h3);
        an_enable = 0;
        for (int k = 0; k < 4; k++)
        begin
            {man_speed_100, man_full_duplex} = 2'(k);
            tick(2);
            cmp_mode(2'(k));
        end
        // Partner loses negotiation ability; page flag still pending
        lp_an_able = 0;
        tick(1);
        rd(`IDX_EXPAN, 16'h0002);
        rd(`IDX_EXPAN, 16'h0000);
        tick(3);
        tally_and_finish();
    end
endmodule : autoneg_ability_registers_tb

// [tb/mgmt_station.sv]
// Model of the station management controller issuing register requests.
// Assumes the registers take a request on the rising edge of clk.
`timescale 1ns/1ps
module mgmt_station
    import an_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Request toward the registers
    output mgmt_req_t req
);
    // One-cycle request; released fields show inverted junk
    task automatic access(input logic rd, input logic wr,
                          input logic [4:0] idx, input logic [15:0] d);
        @(posedge clk);
        #1;
        req = '{rd: rd, wr: wr, index: idx, wdata: d};
        @(posedge clk);
        #1;
        req = '{rd: 1'b0, wr: 1'b0, index: ~idx, wdata: ~d};
    endtask : access

    // Idle at time zero
    initial
    begin
        req = '0;
    end
endmodule : mgmt_station
